// [common/mcu8_pkg.sv]
// shared constants, opcodes and types for the instruction subset core
`default_nettype none
package mcu8_pkg;
	// widths, sizes and stack base
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam int RAM_DEPTH = 64;
	localparam int RAM_AW = 6;
	localparam logic [5:0] STACK_BASE = 6'h08;

	// timing: one machine cycle is two clocks of 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYCLE_CLKS = 2;
	localparam int CYCLE_NS = CLK_PERIOD_NS * CYCLE_CLKS;
	localparam int PRESCALE_DEFAULT = 32;

	// reset values and timer full count
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [7:0] BUS_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h08;
	localparam logic [7:0] TIMER_FULL = 8'hFF;

	// single opcodes
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_BUS_LATCH = 8'h02;
	localparam logic [7:0] OP_BUS_STROBE_RD = 8'h08;
	localparam logic [7:0] OP_EXIT = 8'h83;
	localparam logic [7:0] OP_EXIT_RESTORE = 8'h93;
	localparam logic [7:0] OP_INV_CARRY = 8'hA7;
	localparam logic [7:0] OP_INV_UF0 = 8'h95;
	localparam logic [7:0] OP_INV_UF1 = 8'hB5;
	localparam logic [7:0] OP_ZERO_CARRY = 8'h97;
	localparam logic [7:0] OP_ZERO_UF0 = 8'h85;
	localparam logic [7:0] OP_ZERO_UF1 = 8'hA5;
	localparam logic [7:0] OP_AND_BUS = 8'h98;
	localparam logic [7:0] OP_OR_BUS = 8'h88;
	localparam logic [7:0] OP_TIRQ_ON = 8'h25;
	localparam logic [7:0] OP_TIRQ_OFF = 8'h35;
	localparam logic [7:0] OP_ACC_FROM_TMR = 8'h42;
	localparam logic [7:0] OP_TMR_FROM_ACC = 8'h62;
	localparam logic [7:0] OP_EVENT_BEGIN = 8'h45;
	localparam logic [7:0] OP_TIMER_BEGIN = 8'h55;
	localparam logic [7:0] OP_COUNT_HALT = 8'h65;

	// opcode groups, upper seven bits
	localparam logic [6:0] GRP_XD_RD = 7'h40;
	localparam logic [6:0] GRP_XD_WR = 7'h48;
	localparam logic [6:0] GRP_SWAP_IND = 7'h10;
	localparam logic [6:0] GRP_SWAP_NIB = 7'h18;
	localparam logic [6:0] GRP_INC_IND = 7'h08;
	// opcode groups, upper five bits; the call group is the low five bits
	localparam logic [4:0] GRP_SWAP_REG = 5'h05;
	localparam logic [4:0] GRP_SUB_REG = 5'h19;
	localparam logic [4:0] GRP_ADD_REG = 5'h03;
	localparam logic [4:0] GRP_CALL_LOW = 5'h14;
	// opcode groups, upper six bits
	localparam logic [5:0] GRP_AND_PORT = 6'h26;
	localparam logic [5:0] GRP_OR_PORT = 6'h22;
	localparam logic [5:0] GRP_AND_EXP = 6'h27;
	localparam logic [5:0] GRP_OR_EXP = 6'h23;
	localparam logic [5:0] GRP_IN_PORT = 6'h02;
	localparam logic [5:0] GRP_EXP_RD = 6'h03;
	localparam logic [5:0] GRP_EXP_WR = 6'h0F;
	localparam logic [5:0] GRP_OUT_PORT = 6'h0E;

	// expander command codes
	localparam logic [1:0] EXP_CMD_RD = 2'h0;
	localparam logic [1:0] EXP_CMD_WR = 2'h1;
	localparam logic [1:0] EXP_CMD_OR = 2'h2;
	localparam logic [1:0] EXP_CMD_AND = 2'h3;

	typedef enum logic [1:0] {S_C0P0, S_C0P1, S_C1P0, S_C1P1} step_e;
	typedef enum logic [1:0] {TM_STOP, TM_TIMER, TM_COUNT} tmode_e;

	typedef struct packed {
		logic carry;
		logic half_carry;
		logic user_flag_zero;
		logic bank;
		logic one;
		logic [2:0] stack_ptr;
	} status_word_s;

	typedef struct packed {
		logic [1:0] port_sel;
		logic [1:0] cmd;
		logic [3:0] nibble;
	} exp_req_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
	} xd_req_s;
endpackage : mcu8_pkg
`default_nettype wire

// [hdl/data_ram.sv]
// single port internal data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module data_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// write port, array holds no reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// read returns old data on a same-cycle write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule : data_ram
`default_nettype wire

// [hdl/mcu8_instruction_subset_exec.sv]
// decode and execute core for the move, flag, port, timer and return subset
// Function
// RULE1: external data read into accumulator via R0/R1 address, two cycles
// RULE2: accumulator written to external data at R0/R1 address, two cycles
// RULE3: swap accumulator with working register 0-7, one cycle, flags kept
// RULE4: swap accumulator with internal data at R0/R1 address, one cycle
// RULE5: swap only low nibbles of accumulator and indirect internal byte
// RULE6: invert carry, user flag zero or user flag one in one cycle
// RULE7: clear carry, user flag zero or user flag one in one cycle
// RULE8: and or or immediate byte into bus latch, two cycles two bytes
// RULE9: and or or immediate byte into port 1 or 2 latch, two cycles
// RULE10: and or or accumulator low nibble into expander port 4-7
// RULE11: read port 1 or 2 pins into accumulator, two cycles
// RULE12: strobed bus read into accumulator, two cycles
// RULE13: expander nibble into accumulator low bits, upper bits zero
// RULE14: accumulator low nibble sent to expander port 4-7, two cycles
// RULE15: accumulator loaded into bus output latch, two cycles
// RULE16: accumulator written to port 1 or 2 latch, two cycles
// RULE17: register decrement, register increment, indirect increment, one cycle
// RULE18: pop program counter only, status kept, two cycles
// RULE19: pop program counter and upper status bits, two cycles
// RULE20: enable or disable timer overflow interrupt flag, one cycle
// RULE21: move timer to accumulator or accumulator to timer, one cycle
// RULE22: start timer, start event counting or stop counting, one cycle
// RULE23: program addresses are twelve bits wide
// RULE24: two-byte call pushes counter and status, then jumps, two cycles
// RULE25: no operation only advances the program counter, one cycle
`timescale 1ns/10ps
`default_nettype none
module mcu8_instruction_subset_exec #(
	parameter int TIMER_PRESCALE = mcu8_pkg::PRESCALE_DEFAULT
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// program memory
	output logic [mcu8_pkg::PC_W-1:0] PROG_ADDR,
	input wire logic [7:0] PROG_DATA,
	// external data memory
	output mcu8_pkg::xd_req_s XD_REQ,
	output logic XD_RD,
	output logic XD_WR,
	input wire logic [7:0] XD_RDATA,
	// bus port
	output logic [7:0] BUS_OUT,
	output logic BUS_OE_N,
	input wire logic [7:0] BUS_IN,
	output logic BUS_STROBE,
	// ports 1 and 2
	output logic [7:0] P1_OUT,
	output logic [7:0] P2_OUT,
	input wire logic [7:0] P1_IN,
	input wire logic [7:0] P2_IN,
	// expander ports
	output mcu8_pkg::exp_req_s EXP_REQ,
	output logic EXP_STROBE,
	input wire logic [3:0] EXP_NIB_IN,
	// timer and event input
	input wire logic T1_IN,
	input wire logic IRQ_TAKEN,
	output logic TIMER_IRQ,
	// visible state
	output logic [7:0] ACC,
	output mcu8_pkg::status_word_s STATUS_WORD,
	output logic USER_FLAG_ONE,
	output logic [7:0] TIMER_VALUE,
	output logic INSTR_DONE,
	output logic UNSUPPORTED
);
	localparam int PW = (TIMER_PRESCALE > 1) ? $clog2(TIMER_PRESCALE) : 1;
	localparam logic [PW-1:0] PRESC_LAST = PW'(TIMER_PRESCALE - 1);

	mcu8_pkg::step_e step, next_step;
	mcu8_pkg::tmode_e tmode, next_tmode;
	mcu8_pkg::status_word_s next_sw;
	logic [7:0] ir, imm, ret_lo, acc, next_acc, timer, next_timer;
	logic [7:0] wreg [8];
	logic [7:0] next_bus, next_p1, next_p2, ram_rdata, ram_wdata;
	logic [5:0] ram_addr;
	logic [11:0] pc, next_pc, ret_addr;
	logic [28:0] sync1, sync2;
	logic [PW-1:0] presc;
	logic uf1, next_uf1, irq_en, ovf_pend, t1_prev, ram_we;

	// merge a latch value with accumulator or immediate data
	function automatic logic [7:0] merge(input logic [7:0] cur,
		input logic [7:0] a, input logic [7:0] d,
		input logic wr, input logic am, input logic om);
		merge = wr ? a : am ? (cur & d) : om ? (cur | d) : cur;
	endfunction : merge

	// stack slot address, two bytes per entry
	function automatic logic [5:0] stack_addr(input logic [2:0] p,
		input logic hi);
		stack_addr = mcu8_pkg::STACK_BASE + {2'b00, p, hi};
	endfunction : stack_addr

	// pin inputs pass two flip-flops before use
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {BUS_IN, P1_IN, P2_IN, EXP_NIB_IN, T1_IN};
			sync2 <= sync1;
		end
	end

	wire logic [7:0] bus_pin = sync2[28:21];
	wire logic [7:0] p1_pin = sync2[20:13];
	wire logic [7:0] p2_pin = sync2[12:5];
	wire logic [3:0] exp_pin = sync2[4:1];
	wire logic t1_pin = sync2[0];

	// step flags; opcode comes straight from program memory at fetch
	wire logic first = (step == mcu8_pkg::S_C0P0);
	wire logic at_c0p1 = (step == mcu8_pkg::S_C0P1);
	wire logic at_c1p0 = (step == mcu8_pkg::S_C1P0);
	wire logic at_c1p1 = (step == mcu8_pkg::S_C1P1);
	wire logic [7:0] op = first ? PROG_DATA : ir;
	wire logic port_ok = (op[1:0] == 2'b01) || (op[1:0] == 2'b10);

	// opcode decode
	wire logic d_xd_rd = (op[7:1] == mcu8_pkg::GRP_XD_RD);
	wire logic d_xd_wr = (op[7:1] == mcu8_pkg::GRP_XD_WR);
	wire logic d_swap_reg = (op[7:3] == mcu8_pkg::GRP_SWAP_REG);
	wire logic d_swap_ind = (op[7:1] == mcu8_pkg::GRP_SWAP_IND);
	wire logic d_swap_nib = (op[7:1] == mcu8_pkg::GRP_SWAP_NIB);
	wire logic d_inv_c = (op == mcu8_pkg::OP_INV_CARRY);
	wire logic d_inv_f0 = (op == mcu8_pkg::OP_INV_UF0);
	wire logic d_inv_f1 = (op == mcu8_pkg::OP_INV_UF1);
	wire logic d_zero_c = (op == mcu8_pkg::OP_ZERO_CARRY);
	wire logic d_zero_f0 = (op == mcu8_pkg::OP_ZERO_UF0);
	wire logic d_zero_f1 = (op == mcu8_pkg::OP_ZERO_UF1);
	wire logic d_and_bus = (op == mcu8_pkg::OP_AND_BUS);
	wire logic d_or_bus = (op == mcu8_pkg::OP_OR_BUS);
	wire logic d_and_port = (op[7:2] == mcu8_pkg::GRP_AND_PORT) && port_ok;
	wire logic d_or_port = (op[7:2] == mcu8_pkg::GRP_OR_PORT) && port_ok;
	wire logic d_and_exp = (op[7:2] == mcu8_pkg::GRP_AND_EXP);
	wire logic d_or_exp = (op[7:2] == mcu8_pkg::GRP_OR_EXP);
	wire logic d_in_port = (op[7:2] == mcu8_pkg::GRP_IN_PORT) && port_ok;
	wire logic d_bus_rd = (op == mcu8_pkg::OP_BUS_STROBE_RD);
	wire logic d_exp_rd = (op[7:2] == mcu8_pkg::GRP_EXP_RD);
	wire logic d_exp_wr = (op[7:2] == mcu8_pkg::GRP_EXP_WR);
	wire logic d_bus_wr = (op == mcu8_pkg::OP_BUS_LATCH);
	wire logic d_out_port = (op[7:2] == mcu8_pkg::GRP_OUT_PORT) && port_ok;
	wire logic d_sub_reg = (op[7:3] == mcu8_pkg::GRP_SUB_REG);
	wire logic d_add_reg = (op[7:3] == mcu8_pkg::GRP_ADD_REG);
	wire logic d_inc_ind = (op[7:1] == mcu8_pkg::GRP_INC_IND);
	wire logic d_exit = (op == mcu8_pkg::OP_EXIT);
	wire logic d_exit_rs = (op == mcu8_pkg::OP_EXIT_RESTORE);
	wire logic d_call = (op[4:0] == mcu8_pkg::GRP_CALL_LOW);
	wire logic d_tirq_on = (op == mcu8_pkg::OP_TIRQ_ON);
	wire logic d_tirq_off = (op == mcu8_pkg::OP_TIRQ_OFF);
	wire logic d_a_from_t = (op == mcu8_pkg::OP_ACC_FROM_TMR);
	wire logic d_t_from_a = (op == mcu8_pkg::OP_TMR_FROM_ACC);
	wire logic d_ev_begin = (op == mcu8_pkg::OP_EVENT_BEGIN);
	wire logic d_tm_begin = (op == mcu8_pkg::OP_TIMER_BEGIN);
	wire logic d_halt = (op == mcu8_pkg::OP_COUNT_HALT);
	wire logic d_nop = (op == mcu8_pkg::OP_NOP);

	// instruction classes
	wire logic d_exp_any = d_exp_rd | d_exp_wr | d_and_exp | d_or_exp;
	wire logic d_exit_any = d_exit | d_exit_rs;
	wire logic two_byte = d_and_bus | d_or_bus | d_and_port | d_or_port
		| d_call;
	wire logic two_cyc = two_byte | d_xd_rd | d_xd_wr | d_exp_any
		| d_in_port | d_bus_rd | d_bus_wr | d_out_port | d_exit_any;
	wire logic one_cyc = d_swap_reg | d_swap_ind | d_swap_nib | d_inv_c
		| d_inv_f0 | d_inv_f1 | d_zero_c | d_zero_f0 | d_zero_f1
		| d_sub_reg | d_add_reg | d_inc_ind | d_tirq_on | d_tirq_off
		| d_a_from_t | d_t_from_a | d_ev_begin | d_tm_begin | d_halt
		| d_nop;

	// operand selection
	wire logic [7:0] ind_ptr = wreg[{2'b00, op[0]}];
	wire logic [7:0] wsel = wreg[op[2:0]];
	wire logic [7:0] port_pin = op[1] ? p2_pin : p1_pin;
	wire logic [2:0] sp = STATUS_WORD.stack_ptr;
	wire logic [2:0] sp_m1 = sp - 3'h1;
	wire logic [2:0] sp_p1 = sp + 3'h1;
	wire logic port1 = (op[1:0] == 2'b01);
	wire logic port2 = (op[1:0] == 2'b10);

	// machine cycle sequencer: two clocks a cycle
	always_comb begin
		case (step)
			mcu8_pkg::S_C0P0: next_step = mcu8_pkg::S_C0P1;
			mcu8_pkg::S_C0P1: next_step = two_cyc ? mcu8_pkg::S_C1P0
				: mcu8_pkg::S_C0P0;
			mcu8_pkg::S_C1P0: next_step = mcu8_pkg::S_C1P1;
			mcu8_pkg::S_C1P1: next_step = mcu8_pkg::S_C0P0;
			default: next_step = mcu8_pkg::S_C0P0;
		endcase
	end

	// RULE23: twelve bit counter
	assign ret_addr = pc + 12'h001;
	// RULE25: fetch advances counter
	assign next_pc =
		// RULE24: call jump target
		(at_c1p1 & d_call) ? {pc[11], ir[7:5], imm} :
		// RULE18: pop program counter
		(at_c1p1 & d_exit_any) ? {ram_rdata[3:0], ret_lo} :
		(first | (at_c1p0 & two_byte & ~d_call)) ? ret_addr : pc;

	// internal memory port: indirect operand or stack slot
	assign ram_addr =
		(at_c0p1 & d_exit_any) ? stack_addr(sp_m1, 1'b0) :
		(at_c1p0 & d_exit_any) ? stack_addr(sp_m1, 1'b1) :
		(at_c1p0 & d_call) ? stack_addr(sp, 1'b0) :
		(at_c1p1 & d_call) ? stack_addr(sp, 1'b1) : ind_ptr[5:0];
	// RULE24: push return and status
	assign ram_we = (at_c0p1 & (d_swap_ind | d_swap_nib | d_inc_ind))
		| ((at_c1p0 | at_c1p1) & d_call);
	assign ram_wdata =
		at_c1p0 ? ret_addr[7:0] :
		at_c1p1 ? {STATUS_WORD[7:4], ret_addr[11:8]} :
		// RULE4: memory takes accumulator
		d_swap_ind ? acc :
		// RULE5: low nibble only
		d_swap_nib ? {ram_rdata[7:4], acc[3:0]} :
		// RULE17: indirect increment
		8'(ram_rdata + 8'h01);

	data_ram #(
		.WIDTH(mcu8_pkg::DATA_W),
		.DEPTH(mcu8_pkg::RAM_DEPTH),
		.AW(mcu8_pkg::RAM_AW)
	) u_ram (
		.clk(CLK),
		.rst_n(RST_N),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// accumulator sources
	assign next_acc =
		// RULE3: register swap
		(at_c0p1 & d_swap_reg) ? wsel :
		// RULE4: indirect swap
		(at_c0p1 & d_swap_ind) ? ram_rdata :
		// RULE5: nibble swap
		(at_c0p1 & d_swap_nib) ? {acc[7:4], ram_rdata[3:0]} :
		// RULE21: timer into accumulator
		(at_c0p1 & d_a_from_t) ? timer :
		// RULE1: external read
		(at_c1p1 & d_xd_rd) ? XD_RDATA :
		// RULE11: port pins read
		(at_c1p1 & d_in_port) ? port_pin :
		// RULE12: strobed bus read
		(at_c1p1 & d_bus_rd) ? bus_pin :
		// RULE13: upper nibble zeroed
		(at_c1p1 & d_exp_rd) ? {4'h0, exp_pin} : acc;

	// flag and stack pointer updates
	assign next_sw.carry =
		// RULE6: invert carry
		(at_c0p1 & d_inv_c) ? ~STATUS_WORD.carry :
		// RULE7: clear carry
		(at_c0p1 & d_zero_c) ? 1'b0 :
		// RULE19: restore upper status
		(at_c1p1 & d_exit_rs) ? ram_rdata[7] : STATUS_WORD.carry;
	assign next_sw.half_carry = (at_c1p1 & d_exit_rs) ? ram_rdata[6]
		: STATUS_WORD.half_carry;
	assign next_sw.user_flag_zero =
		// RULE6: invert flag zero
		(at_c0p1 & d_inv_f0) ? ~STATUS_WORD.user_flag_zero :
		// RULE7: clear flag zero
		(at_c0p1 & d_zero_f0) ? 1'b0 :
		(at_c1p1 & d_exit_rs) ? ram_rdata[5] : STATUS_WORD.user_flag_zero;
	assign next_sw.bank = (at_c1p1 & d_exit_rs) ? ram_rdata[4]
		: STATUS_WORD.bank;
	assign next_sw.one = 1'b1;
	assign next_sw.stack_ptr =
		// RULE24: push raises pointer
		(at_c1p1 & d_call) ? sp_p1 :
		// RULE18: pop lowers pointer
		(at_c1p1 & d_exit_any) ? sp_m1 : sp;
	// RULE6: invert flag one
	assign next_uf1 = (at_c0p1 & d_inv_f1) ? ~uf1 :
		// RULE7: clear flag one
		(at_c0p1 & d_zero_f1) ? 1'b0 : uf1;

	// output latch merges at the end of cycle two
	wire logic latch_time = at_c1p1;
	// RULE8: bus latch merge
	// RULE15: accumulator to bus
	assign next_bus = merge(BUS_OUT, acc, imm, latch_time & d_bus_wr,
		latch_time & d_and_bus, latch_time & d_or_bus);
	// RULE9: port latch merge
	// RULE16: accumulator to port
	assign next_p1 = merge(P1_OUT, acc, imm, latch_time & d_out_port & port1,
		latch_time & d_and_port & port1, latch_time & d_or_port & port1);
	assign next_p2 = merge(P2_OUT, acc, imm, latch_time & d_out_port & port2,
		latch_time & d_and_port & port2, latch_time & d_or_port & port2);

	// bus and expander strobes span cycle zero phase one to the end; data strobes pulse at cycle one phase zero
	// RULE1: read strobe
	assign XD_RD = at_c1p0 & d_xd_rd;
	// RULE2: write strobe
	assign XD_WR = at_c1p0 & d_xd_wr;
	// RULE12: bus strobe window
	assign BUS_STROBE = ~first & d_bus_rd;
	// RULE10: expander strobe window
	assign EXP_STROBE = ~first & d_exp_any;

	// timer step source
	wire logic presc_wrap = (at_c0p1 | at_c1p1) && (presc == PRESC_LAST);
	wire logic t1_fall = t1_prev & ~t1_pin;
	wire logic tmr_step = (tmode == mcu8_pkg::TM_TIMER) ? presc_wrap
		: (tmode == mcu8_pkg::TM_COUNT) ? t1_fall : 1'b0;
	wire logic tmr_load = at_c0p1 & d_t_from_a;
	wire logic overflow = tmr_step & ~tmr_load
		& (timer == mcu8_pkg::TIMER_FULL);
	// RULE21: accumulator into timer
	assign next_timer = tmr_load ? acc : tmr_step ? 8'(timer + 8'h01)
		: timer;
	// RULE22: count mode select
	assign next_tmode = ~at_c0p1 ? tmode :
		d_tm_begin ? mcu8_pkg::TM_TIMER :
		d_ev_begin ? mcu8_pkg::TM_COUNT :
		d_halt ? mcu8_pkg::TM_STOP : tmode;

	// core state
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			step <= mcu8_pkg::S_C0P0;
			pc <= '0;
			ir <= mcu8_pkg::OP_NOP;
			acc <= '0;
			STATUS_WORD <= mcu8_pkg::STATUS_RESET;
			uf1 <= 1'b0;
		end else begin
			step <= next_step;
			pc <= next_pc;
			ir <= first ? PROG_DATA : ir;
			acc <= next_acc;
			STATUS_WORD <= next_sw;
			uf1 <= next_uf1;
		end
	end

	// operand capture for two cycle instructions
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			imm <= '0;
			ret_lo <= '0;
		end else if (at_c1p0) begin
			imm <= PROG_DATA;
			ret_lo <= ram_rdata;
		end
	end

	// working registers
	wire logic wreg_we = at_c0p1 & (d_swap_reg | d_add_reg | d_sub_reg);
	// RULE3: register takes accumulator
	// RULE17: register step
	wire logic [7:0] wreg_wd = d_swap_reg ? acc : d_add_reg
		? 8'(wsel + 8'h01) : 8'(wsel - 8'h01);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wreg <= '{default: 8'h00};
		end else if (wreg_we) begin
			wreg[op[2:0]] <= wreg_wd;
		end
	end

	// external data and expander requests, loaded at cycle zero phase one
	wire logic [1:0] exp_cmd = d_exp_rd ? mcu8_pkg::EXP_CMD_RD :
		d_exp_wr ? mcu8_pkg::EXP_CMD_WR :
		d_or_exp ? mcu8_pkg::EXP_CMD_OR : mcu8_pkg::EXP_CMD_AND;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			XD_REQ <= '0;
			EXP_REQ <= '0;
		end else if (at_c0p1) begin
			// RULE2: address and data
			if (d_xd_rd | d_xd_wr) XD_REQ <= {ind_ptr, acc};
			// RULE14: nibble and port select
			if (d_exp_any) EXP_REQ <= {op[1:0], exp_cmd, acc[3:0]};
		end
	end

	// bus and port latches; bus floats after a strobed read
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BUS_OUT <= mcu8_pkg::BUS_RESET;
			BUS_OE_N <= 1'b1;
			P1_OUT <= mcu8_pkg::PORT_RESET;
			P2_OUT <= mcu8_pkg::PORT_RESET;
		end else begin
			BUS_OUT <= next_bus;
			if (latch_time & (d_bus_wr | d_and_bus | d_or_bus)) BUS_OE_N <= 1'b0;
			else if (at_c0p1 & d_bus_rd) BUS_OE_N <= 1'b1;
			P1_OUT <= next_p1;
			P2_OUT <= next_p2;
		end
	end

	// timer, prescaler and overflow interrupt flag
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			timer <= '0;
			tmode <= mcu8_pkg::TM_STOP;
			presc <= '0;
			t1_prev <= 1'b0;
			irq_en <= 1'b0;
			ovf_pend <= 1'b0;
		end else begin
			timer <= next_timer;
			tmode <= next_tmode;
			t1_prev <= t1_pin;
			if (at_c0p1 & d_tm_begin) presc <= '0;
			else if (tmode == mcu8_pkg::TM_TIMER && (at_c0p1 | at_c1p1))
				presc <= presc_wrap ? '0 : PW'(presc + 1'b1);
			// RULE20: interrupt enable flag
			if (at_c0p1 & d_tirq_on) irq_en <= 1'b1;
			else if (at_c0p1 & d_tirq_off) irq_en <= 1'b0;
			// overflow set wins over clear
			if (overflow) ovf_pend <= 1'b1;
			else if (IRQ_TAKEN | (at_c0p1 & d_tirq_off)) ovf_pend <= 1'b0;
		end
	end

	// visible state and instruction completion
	assign PROG_ADDR = pc;
	assign ACC = acc;
	assign USER_FLAG_ONE = uf1;
	assign TIMER_VALUE = timer;
	assign TIMER_IRQ = irq_en & ovf_pend;
	assign INSTR_DONE = (at_c0p1 & ~two_cyc) | at_c1p1;
	assign UNSUPPORTED = at_c0p1 & ~one_cyc & ~two_cyc;
endmodule : mcu8_instruction_subset_exec
`default_nettype wire

// [dv/ext_mem.sv]
// program store and external data memory model
`timescale 1ns/10ps
`default_nettype none
module ext_mem (
	// clock
	input wire logic clk,
	// program store
	input wire logic [11:0] prog_addr,
	output logic [7:0] prog_data,
	// external data
	input wire mcu8_pkg::xd_req_s xd_req,
	input wire logic xd_rd,
	input wire logic xd_wr,
	output logic [7:0] xd_rdata
);
	logic [7:0] prog [4096];
	logic [7:0] xd [256];
	// fetch byte with no wait state
	assign prog_data = prog[prog_addr];
	// registered memory reply
	// idle data lines toggle so a stale read shows
	always @(posedge clk) begin
		if (xd_wr)
			xd[xd_req.addr] <= xd_req.wdata;
		if (xd_rd)
			xd_rdata <= xd[xd_req.addr];
		else
			xd_rdata <= ~xd_rdata;
	end
	// empty program space reads as no-operation
	initial begin
		xd_rdata = 8'h00;
		for (int i = 0; i < 4096; i++)
			prog[i] = 8'h00;
	end
endmodule : ext_mem
`default_nettype wire

// [dv/exec_asserts.sv]
// port timing checks for the instruction subset core
`timescale 1ns/10ps
`default_nettype none
module exec_asserts (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// watched outputs
	input wire mcu8_pkg::xd_req_s XD_REQ,
	input wire logic XD_RD,
	input wire logic XD_WR,
	input wire logic BUS_STROBE,
	input wire logic EXP_STROBE,
	input wire logic BUS_OE_N,
	input wire logic [7:0] BUS_OUT,
	input wire logic [7:0] P1_OUT,
	input wire logic [7:0] P2_OUT,
	input wire logic [7:0] ACC,
	input wire logic INSTR_DONE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// strobe high three clocks then low
	sequence held3(s);
		s [*3] ##1 !s;
	endsequence
	// external data strobes
	xd_rd_pulse_a: assert property (XD_RD |=> !XD_RD && INSTR_DONE)
		else $error("read strobe timing");
	xd_wr_data_a: assert property (XD_WR |->
		XD_REQ.wdata == ACC ##1 !XD_WR && INSTR_DONE)
		else $error("write data or timing");
	// strobed reads and expander access
	bus_strobe_a: assert property ($rose(BUS_STROBE) |-> held3(BUS_STROBE))
		else $error("bus strobe length");
	bus_float_a: assert property ($rose(BUS_STROBE) |=> BUS_OE_N)
		else $error("bus not floated");
	exp_strobe_a: assert property ($rose(EXP_STROBE) |->
		held3(EXP_STROBE) and ##2 INSTR_DONE)
		else $error("expander strobe");
	// instruction end and latch updates
	done_pulse_a: assert property (INSTR_DONE |=> !INSTR_DONE)
		else $error("done not a pulse");
	bus_drive_a: assert property ($changed(BUS_OUT) |->
		!BUS_OE_N && $past(INSTR_DONE))
		else $error("bus latch update");
	port_latch_a: assert property ($changed(P1_OUT) || $changed(P2_OUT)
		|-> $past(INSTR_DONE))
		else $error("port latch update");
endmodule : exec_asserts
bind mcu8_instruction_subset_exec exec_asserts chk (
	.CLK(CLK), .RST_N(RST_N), .XD_REQ(XD_REQ), .XD_RD(XD_RD),
	.XD_WR(XD_WR), .BUS_STROBE(BUS_STROBE), .EXP_STROBE(EXP_STROBE),
	.BUS_OE_N(BUS_OE_N), .BUS_OUT(BUS_OUT), .P1_OUT(P1_OUT),
	.P2_OUT(P2_OUT), .ACC(ACC), .INSTR_DONE(INSTR_DONE)
);
`default_nettype wire

// [dv/mcu8_instruction_subset_exec_tb.sv]
// self-checking bench running a short program through the core
`timescale 1ns/10ps
`default_nettype none
module mcu8_instruction_subset_exec_tb;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] p1_in = 8'h05, p2_in = 8'hA3, bus_in = 8'h5A;
	logic [3:0] nib_in = 4'h9;
	logic t1 = 1'b0, irq_tk = 1'b0;
	logic [11:0] pa;
	logic [7:0] pd, xdr, bus_out, p1o, p2o, acc, tmr;
	logic xrd, xwr, oe_n, bstb, estb, tirq, uf1, done, unsup, unsup_seen;
	mcu8_pkg::xd_req_s xdq;
	mcu8_pkg::exp_req_s expq;
	mcu8_pkg::status_word_s sw;
	int mismatches = 0;
	int total_checks = 0;
	logic [7:0] code [43] = '{8'h09, 8'h28, 8'h0A, 8'h90, 8'h09, 8'h80,
		8'h18, 8'h28, 8'hA7, 8'h97, 8'h95, 8'h85, 8'hB5, 8'hA5, 8'h3A,
		8'h02, 8'h88, 8'hF0, 8'h99, 8'h03, 8'h89, 8'h30, 8'h3C, 8'h9D,
		8'h8E, 8'h0D, 8'h08, 8'h62, 8'h00, 8'h14, 8'h40, 8'h20, 8'h09,
		8'h30, 8'h10, 8'h20, 8'hC8, 8'h28, 8'h23, 8'h25, 8'h55, 8'h14,
		8'h29};
	// machine clock
	always #2 CLK = ~CLK;
	mcu8_instruction_subset_exec #(.TIMER_PRESCALE(2)) uut (
		.CLK(CLK), .RST_N(RST_N), .PROG_ADDR(pa), .PROG_DATA(pd),
		.XD_REQ(xdq), .XD_RD(xrd), .XD_WR(xwr), .XD_RDATA(xdr),
		.BUS_OUT(bus_out), .BUS_OE_N(oe_n), .BUS_IN(bus_in),
		.BUS_STROBE(bstb), .P1_OUT(p1o), .P2_OUT(p2o), .P1_IN(p1_in),
		.P2_IN(p2_in), .EXP_REQ(expq), .EXP_STROBE(estb),
		.EXP_NIB_IN(nib_in), .T1_IN(t1), .IRQ_TAKEN(irq_tk),
		.TIMER_IRQ(tirq), .ACC(acc), .STATUS_WORD(sw),
		.USER_FLAG_ONE(uf1), .TIMER_VALUE(tmr), .INSTR_DONE(done),
		.UNSUPPORTED(unsup));
	ext_mem mem (.clk(CLK), .prog_addr(pa), .prog_data(pd),
		.xd_req(xdq), .xd_rd(xrd), .xd_wr(xwr), .xd_rdata(xdr));
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// one instruction: wait for its done pulse, let results land
	task automatic step();
		int n;
		for (n = 0; n < 20 && done !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		unsup_seen = unsup;
		if (n == 20) begin
			mismatches++;
			$display("mismatch at %0t: no done", $time);
			wrap_up();
		end else begin
			@(posedge CLK);
			#1;
		end
	endtask : step
	// main sequence
	initial begin
		#1;
		for (int i = 0; i < 43; i++)
			mem.prog[i] = code[i];
		mem.prog[12'h040] = 8'h0A;
		mem.prog[12'h041] = 8'h42;
		mem.prog[12'h042] = 8'h83;
		repeat (10) @(posedge CLK);
		chk(p1o, mcu8_pkg::PORT_RESET);
		chk(sw, mcu8_pkg::STATUS_RESET);
		#1 RST_N = 1'b1;
		step();
		chk(acc, 8'h05);
		step();
		step();
		chk(acc, 8'hA3);
		step();
		chk(xdq.addr, 8'h05);
		step();
		step();
		chk(acc, 8'hA3);
		step();
		step();
		chk(acc, 8'h06);
		chk(sw, 8'h08);
		$display("test moves done");
		step();
		chk(sw, 8'h88);
		step();
		chk(sw, 8'h08);
		step();
		chk(sw, 8'h28);
		step();
		chk(sw, 8'h08);
		step();
		chk({7'h00, uf1}, 8'h01);
		step();
		chk({7'h00, uf1}, 8'h00);
		$display("test flags done");
		step();
		chk(p2o, 8'h06);
		step();
		chk(bus_out, 8'h06);
		step();
		chk(bus_out, 8'hF6);
		step();
		chk(p1o, 8'h03);
		step();
		chk(p1o, 8'h33);
		step();
		chk(expq, 8'h16);
		step();
		chk(expq, 8'h76);
		step();
		chk(expq, 8'hA6);
		step();
		chk(acc, 8'h09);
		step();
		chk(acc, 8'h5A);
		$display("test ports done");
		step();
		chk(tmr, 8'h5A);
		step();
		chk(pa[7:0], 8'h1D);
		step();
		chk(pa[7:0], 8'h40);
		chk(sw, 8'h09);
		step();
		step();
		chk(acc, 8'h5A);
		step();
		chk(pa[7:0], 8'h1F);
		chk(sw, 8'h08);
		$display("test calls done");
		// indirect swaps, nibble swap, register step, unknown opcode
		step();
		step();
		step();
		chk(acc, 8'h0A);
		step();
		step();
		chk(acc, 8'h56);
		step();
		step();
		chk(acc, 8'hA2);
		step();
		chk({7'h00, unsup_seen}, 8'h01);
		chk(acc, 8'hA2);
		// timer runs from 5A while a call spins on itself
		step();
		step();
		for (int n = 0; n < 1000 && tirq !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
		chk({7'h00, tirq}, 8'h01);
		chk(tmr, 8'h00);
		irq_tk = 1'b1;
		@(posedge CLK);
		#1 irq_tk = 1'b0;
		chk({7'h00, tirq}, 8'h00);
		$display("test timer done");
		wrap_up();
	end
endmodule : mcu8_instruction_subset_exec_tb
`default_nettype wire
